// >>> verilog/fpec_top.v
// Purpose: flash page ecc corrector, syndrome/locate/correct pipeline
// Assumes: one 100 MHz clock; memory port answers reads after a grant
// Notes:   locator is a single-error position code per unit
`timescale 1ns/100ps
`include "fpec_regs.vh"
module fpec_top #(
  parameter BW_W = 11
) (
  // clock and reset
  input  wire             CLK,
  input  wire             RESET_N,
  // page command, sampled on START
  input  wire             START,
  input  wire [1:0]       MODE,
  input  wire             SRC_MEM,
  input  wire             FIRST_ONLY,
  input  wire [4:0]       STRENGTH,
  input  wire [7:0]       META_BYTES,
  input  wire             META_OWN,
  input  wire [BW_W-1:0]  BLOCK_WORDS,
  input  wire [7:0]       BLOCK_COUNT,
  input  wire [31:0]      SRC_ADDR,
  input  wire [31:0]      DST_ADDR,
  // media word stream
  input  wire             MEDIA_VALID,
  input  wire [31:0]      MEDIA_DATA,
  output reg              MEDIA_READY,
  // memory master
  output reg              MEM_REQ,
  output reg              MEM_WE,
  output reg  [31:0]      MEM_ADDR,
  output reg  [31:0]      MEM_WDATA,
  input  wire             MEM_GNT,
  input  wire             MEM_RVALID,
  input  wire [31:0]      MEM_RDATA,
  // status
  output reg              BUSY,
  output reg              DONE,
  output reg              STAT_VALID,
  output reg  [7:0]       STAT_INDEX,
  output reg  [4:0]       STAT_COUNT,
  output reg              STAT_UNCORR
);
  // xor of the indices of all set bits in a word
  function [4:0] bit_loc;
    input [31:0] w;
    integer i;
    begin
      bit_loc = 5'h00;
      for (i = 0; i < 32; i = i + 1) begin
        if (w[i]) begin
          bit_loc = bit_loc ^ i[4:0];
        end
      end
    end
  endfunction

  // parity bit and position code of one word at index idx
  function [16:0] word_syn;
    input [31:0]     w;
    input [BW_W-1:0] idx;
    begin
      word_syn = {^w, (^w ? idx : {BW_W{1'b0}}), bit_loc(w)};
    end
  endfunction

  reg              run_q;
  reg              enc_q;
  reg              src_mem_q;
  reg  [3:0]       pw_q;
  reg  [7:0]       units_q;
  reg  [7:0]       unit_q;
  reg  [BW_W-1:0]  len0_q;
  reg  [BW_W-1:0]  lenn_q;
  reg  [BW_W-1:0]  wcnt_q;
  reg              in_par_q;
  reg  [3:0]       pcnt_q;
  reg  [16:0]      acc_q;
  reg  [31:0]      ubase_q;
  reg  [31:0]      wr_addr_q;
  reg  [31:0]      src_addr_q;
  reg  [19:0]      fetch_left_q;
  reg              kes_v_q;
  reg              kes_chk_q;
  reg  [16:0]      kes_syn_q;
  reg  [31:0]      kes_base_q;
  reg  [BW_W-1:0]  kes_len_q;
  reg  [7:0]       kes_idx_q;
  reg              cs_v_q;
  reg  [31:0]      cs_addr_q;
  reg  [31:0]      cs_mask_q;
  reg  [1:0]       ms_q;
  reg  [1:0]       op_q;

  wire             f_in_valid;
  wire             f_in_ready;
  wire             f_out_valid;
  wire [31:0]      f_out_data;
  wire [4:0]       f_count;
  wire             fetch_push;
  wire [BW_W-1:0]  ulen;
  wire             last_word;
  wire             last_par;
  wire [16:0]      acc_nx;
  wire             ing_on;
  wire             sel_rmw;
  wire             sel_emit;
  wire             sel_store;
  wire             sel_chk;
  wire             sel_fetch;
  wire             kes_go;
  wire [BW_W-1:0]  err_word;
  wire             err_one;
  wire             page_end;
  wire [4:0]       str_c;
  wire [BW_W-1:0]  mw_c;
  wire             mown_c;
  wire [7:0]       nblk_c;
  wire [7:0]       nun_c;
  wire [19:0]      tot_c;

  // command decode at start
  assign str_c  = (STRENGTH > `FPEC_STR_MAX) ? `FPEC_STR_MAX : {STRENGTH[4:1], 1'b0};
  assign mw_c   = {{(BW_W-6){1'b0}}, META_BYTES[7:2]} + {{(BW_W-1){1'b0}}, |META_BYTES[1:0]};
  assign mown_c = META_OWN && (mw_c != {BW_W{1'b0}});
  // encode ignores first-only: no partial page on the write side
  assign nblk_c = (FIRST_ONLY && MODE != `FPEC_MODE_ENC) ? 8'h01 : BLOCK_COUNT;
  assign nun_c  = nblk_c + {7'h00, mown_c};
  assign tot_c  = {{(20-BW_W){1'b0}}, mw_c} + nblk_c * BLOCK_WORDS
                + ((MODE != `FPEC_MODE_ENC) ? nun_c * str_c[4:1] : 20'h00000);

  assign ulen      = (unit_q == 8'h00) ? len0_q : lenn_q;
  assign last_word = (wcnt_q == ulen - 1'b1);
  assign last_par  = (pcnt_q == pw_q - 1'b1);
  assign acc_nx    = acc_q ^ word_syn(f_out_data, wcnt_q);
  assign ing_on    = run_q && (unit_q != units_q);
  assign page_end  = run_q && !ing_on && !kes_v_q && !cs_v_q && !in_par_q
                   && (ms_q == `FPEC_MEM_IDLE);

  // memory arbitration: correction first so the pipeline drains
  assign sel_rmw   = cs_v_q;
  assign sel_emit  = !sel_rmw && in_par_q && enc_q;
  assign sel_store = !sel_rmw && !sel_emit && ing_on && !in_par_q
                   && f_out_valid && !kes_v_q;
  assign sel_chk   = !sel_rmw && ing_on && in_par_q && !enc_q
                   && f_out_valid && !kes_v_q;
  assign sel_fetch = !sel_rmw && !sel_emit && !sel_store && src_mem_q
                   && (fetch_left_q != 20'h00000) && f_in_ready;

  assign fetch_push = (ms_q == `FPEC_MEM_RD) && (op_q == `FPEC_OP_FETCH) && MEM_RVALID;
  assign f_in_valid = src_mem_q ? fetch_push : (MEDIA_VALID && MEDIA_READY);

  fpec_fifo #(
    .W  (32),
    .D  (`FPEC_FIFO_DEPTH),
    .AW (4)
  ) u_fifo (
    .clk       (CLK),
    .reset_n   (RESET_N),
    .in_valid  (f_in_valid),
    .in_ready  (f_in_ready),
    .in_data   (src_mem_q ? MEM_RDATA : MEDIA_DATA),
    .out_valid (f_out_valid),
    .out_ready ((ms_q == `FPEC_MEM_IDLE) && (sel_store || sel_chk)),
    .out_data  (f_out_data),
    .count     (f_count)
  );

  // locator: odd parity with an in-range position is one bit error
  assign kes_go   = kes_v_q && !cs_v_q;
  assign err_word = kes_syn_q[15:5];
  assign err_one  = kes_syn_q[16] && (err_word < kes_len_q);

  always @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      run_q        <= 1'b0;
      enc_q        <= 1'b0;
      src_mem_q    <= 1'b0;
      pw_q         <= 4'h0;
      units_q      <= 8'h00;
      unit_q       <= 8'h00;
      len0_q       <= {BW_W{1'b0}};
      lenn_q       <= {BW_W{1'b0}};
      wcnt_q       <= {BW_W{1'b0}};
      in_par_q     <= 1'b0;
      pcnt_q       <= 4'h0;
      acc_q        <= 17'h00000;
      ubase_q      <= 32'h00000000;
      wr_addr_q    <= 32'h00000000;
      src_addr_q   <= 32'h00000000;
      fetch_left_q <= 20'h00000;
      kes_v_q      <= 1'b0;
      kes_chk_q    <= 1'b0;
      kes_syn_q    <= 17'h00000;
      kes_base_q   <= 32'h00000000;
      kes_len_q    <= {BW_W{1'b0}};
      kes_idx_q    <= 8'h00;
      cs_v_q       <= 1'b0;
      cs_addr_q    <= 32'h00000000;
      cs_mask_q    <= 32'h00000000;
      ms_q         <= `FPEC_MEM_IDLE;
      op_q         <= `FPEC_OP_STORE;
      MEDIA_READY  <= 1'b0;
      MEM_REQ      <= 1'b0;
      MEM_WE       <= 1'b0;
      MEM_ADDR     <= 32'h00000000;
      MEM_WDATA    <= 32'h00000000;
      BUSY         <= 1'b0;
      DONE         <= 1'b0;
      STAT_VALID   <= 1'b0;
      STAT_INDEX   <= 8'h00;
      STAT_COUNT   <= 5'h00;
      STAT_UNCORR  <= 1'b0;
    end else begin
      DONE        <= 1'b0;
      STAT_VALID  <= 1'b0;
      BUSY        <= run_q;
      // two words of margin since ready is registered
      MEDIA_READY <= ing_on && !src_mem_q && (f_count <= 5'h0e);
      if (!run_q && START) begin
        run_q        <= 1'b1;
        enc_q        <= (MODE == `FPEC_MODE_ENC);
        src_mem_q    <= SRC_MEM;
        pw_q         <= str_c[4:1];
        units_q      <= nun_c;
        unit_q       <= 8'h00;
        // metadata leads the page, alone or ahead of block 0
        len0_q       <= mown_c ? mw_c : mw_c + BLOCK_WORDS;
        lenn_q       <= BLOCK_WORDS;
        wcnt_q       <= {BW_W{1'b0}};
        acc_q        <= 17'h00000;
        wr_addr_q    <= DST_ADDR;
        src_addr_q   <= SRC_ADDR;
        fetch_left_q <= SRC_MEM ? tot_c : 20'h00000;
      end
      if (page_end) begin
        run_q <= 1'b0;
        DONE  <= 1'b1;
      end
      // locate stage
      if (kes_go) begin
        kes_v_q     <= 1'b0;
        STAT_VALID  <= 1'b1;
        STAT_INDEX  <= kes_idx_q;
        STAT_COUNT  <= 5'h00;
        STAT_UNCORR <= 1'b0;
        if (kes_chk_q && kes_syn_q != 17'h00000) begin
          if (err_one) begin
            cs_v_q     <= 1'b1;
            cs_addr_q  <= kes_base_q + {{(30-BW_W){1'b0}}, err_word, 2'b00};
            cs_mask_q  <= 32'h00000001 << kes_syn_q[4:0];
            STAT_COUNT <= 5'h01;
          end else begin
            STAT_UNCORR <= 1'b1;
          end
        end
      end
      case (ms_q)
        `FPEC_MEM_IDLE: begin
          if (sel_rmw) begin
            MEM_REQ  <= 1'b1;
            MEM_WE   <= 1'b0;
            MEM_ADDR <= cs_addr_q;
            op_q     <= `FPEC_OP_RMW;
            ms_q     <= `FPEC_MEM_REQ;
          end else if (sel_emit) begin
            MEM_REQ   <= 1'b1;
            MEM_WE    <= 1'b1;
            MEM_ADDR  <= wr_addr_q;
            MEM_WDATA <= (pcnt_q == 4'h0) ? {acc_q[16], 15'h0000, acc_q[15:0]} : 32'h00000000;
            wr_addr_q <= wr_addr_q + 32'h00000004;
            op_q      <= `FPEC_OP_STORE;
            ms_q      <= `FPEC_MEM_REQ;
            pcnt_q    <= pcnt_q + 4'h1;
            if (last_par) begin
              in_par_q <= 1'b0;
              acc_q    <= 17'h00000;
              unit_q   <= unit_q + 8'h01;
            end
          end else if (sel_store) begin
            MEM_REQ   <= 1'b1;
            MEM_WE    <= 1'b1;
            MEM_ADDR  <= wr_addr_q;
            MEM_WDATA <= f_out_data;
            wr_addr_q <= wr_addr_q + 32'h00000004;
            op_q      <= `FPEC_OP_STORE;
            ms_q      <= `FPEC_MEM_REQ;
            acc_q     <= acc_nx;
            wcnt_q    <= last_word ? {BW_W{1'b0}} : wcnt_q + 1'b1;
            if (wcnt_q == {BW_W{1'b0}}) begin
              ubase_q <= wr_addr_q;
            end
            if (last_word) begin
              if (pw_q != 4'h0) begin
                in_par_q <= 1'b1;
                pcnt_q   <= 4'h0;
              end else begin
                // strength zero: report only when decoding, never check
                acc_q      <= 17'h00000;
                unit_q     <= unit_q + 8'h01;
                kes_v_q    <= !enc_q;
                kes_chk_q  <= 1'b0;
                kes_syn_q  <= 17'h00000;
                kes_idx_q  <= unit_q;
              end
            end
          end else if (sel_chk) begin
            pcnt_q <= pcnt_q + 4'h1;
            if (pcnt_q == 4'h0) begin
              acc_q <= acc_q ^ {f_out_data[`FPEC_PAR_BIT], f_out_data[15:0]};
            end
            if (last_par) begin
              // whole unit in hand before locating starts
              in_par_q   <= 1'b0;
              acc_q      <= 17'h00000;
              unit_q     <= unit_q + 8'h01;
              kes_v_q    <= 1'b1;
              kes_chk_q  <= 1'b1;
              kes_syn_q  <= (pcnt_q == 4'h0) ?
                            acc_q ^ {f_out_data[`FPEC_PAR_BIT], f_out_data[15:0]} : acc_q;
              kes_base_q <= ubase_q;
              kes_len_q  <= ulen;
              kes_idx_q  <= unit_q;
            end
          end else if (sel_fetch) begin
            MEM_REQ  <= 1'b1;
            MEM_WE   <= 1'b0;
            MEM_ADDR <= src_addr_q;
            op_q     <= `FPEC_OP_FETCH;
            ms_q     <= `FPEC_MEM_REQ;
          end
        end
        `FPEC_MEM_REQ: begin
          if (MEM_GNT) begin
            MEM_REQ <= 1'b0;
            if (MEM_WE) begin
              ms_q <= `FPEC_MEM_IDLE;
              if (op_q == `FPEC_OP_RMW) begin
                cs_v_q <= 1'b0;
              end
            end else begin
              ms_q <= `FPEC_MEM_RD;
            end
          end
        end
        `FPEC_MEM_RD: begin
          if (MEM_RVALID) begin
            if (op_q == `FPEC_OP_RMW) begin
              MEM_REQ   <= 1'b1;
              MEM_WE    <= 1'b1;
              MEM_WDATA <= MEM_RDATA ^ cs_mask_q;
              ms_q      <= `FPEC_MEM_REQ;
            end else begin
              src_addr_q   <= src_addr_q + 32'h00000004;
              fetch_left_q <= fetch_left_q - 20'h00001;
              ms_q         <= `FPEC_MEM_IDLE;
            end
          end
        end
        default: begin
          ms_q <= `FPEC_MEM_IDLE;
        end
      endcase
    end
  end
endmodule // fpec_top

// >>> verilog/fpec_regs.vh
// Purpose: shared constants for the flash page ecc corrector
// Assumes: included by fpec_top.v and fpec_fifo.v
// Notes:   definitions only
`ifndef FPEC_REGS_VH
`define FPEC_REGS_VH
`define FPEC_DATA_W      32
`define FPEC_FIFO_DEPTH  16
`define FPEC_STR_MAX     5'h14
`define FPEC_PAR_BIT     31
`define FPEC_LOC_W       16
`define FPEC_MODE_DEC    2'h0
`define FPEC_MODE_ENC    2'h1
`define FPEC_MEM_IDLE    2'h0
`define FPEC_MEM_REQ     2'h1
`define FPEC_MEM_RD      2'h2
`define FPEC_OP_STORE    2'h0
`define FPEC_OP_FETCH    2'h1
`define FPEC_OP_RMW      2'h2
`endif

// >>> verilog/fpec_fifo.v
// Purpose: data buffer between the word source and the memory writer
// Assumes: single clock, asynchronous active-low reset
// Notes:   push needs in_ready, pop needs out_valid
`timescale 1ns/100ps
`include "fpec_regs.vh"
module fpec_fifo #(
  parameter W  = `FPEC_DATA_W,
  parameter D  = `FPEC_FIFO_DEPTH,
  parameter AW = 4
) (
  // clock and reset
  input  wire          clk,
  input  wire          reset_n,
  // fill side
  input  wire          in_valid,
  output wire          in_ready,
  input  wire [W-1:0]  in_data,
  // drain side
  output wire          out_valid,
  input  wire          out_ready,
  output wire [W-1:0]  out_data,
  // fill level
  output wire [AW:0]   count
);
  reg [W-1:0]  mem_q [0:D-1];
  reg [AW-1:0] wp_q;
  reg [AW-1:0] rp_q;
  reg [AW:0]   cnt_q;
  wire         push;
  wire         pop;

  assign in_ready  = (cnt_q != D[AW:0]);
  assign out_valid = (cnt_q != {(AW+1){1'b0}});
  assign out_data  = mem_q[rp_q];
  assign count     = cnt_q;
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always @(posedge clk) begin
    if (push) begin
      mem_q[wp_q] <= in_data;
    end
  end

  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      wp_q  <= {AW{1'b0}};
      rp_q  <= {AW{1'b0}};
      cnt_q <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wp_q <= (wp_q == D[AW-1:0] - 1'b1) ? {AW{1'b0}} : wp_q + 1'b1;
      end
      if (pop) begin
        rp_q <= (rp_q == D[AW-1:0] - 1'b1) ? {AW{1'b0}} : rp_q + 1'b1;
      end
      cnt_q <= cnt_q + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
    end
  end
endmodule // fpec_fifo

// >>> verif/fpec_mem_model.sv
// Purpose: system memory partner that grants after a random delay
// Assumes: one transaction at a time, word addressing
// Notes:   idle read data toggles, so a stale word never looks valid
`timescale 1ns/100ps
module fpec_mem_model (
  // clock and reset
  input  wire        clk,
  input  wire        reset_n,
  // memory slave
  input  wire        req,
  input  wire        we,
  input  wire [31:0] addr,
  input  wire [31:0] wdata,
  output reg         gnt,
  output reg         rvalid,
  output reg  [31:0] rdata
);
  logic [31:0] mem [int];
  int          seed = 11844;
  int          slow = 0;
  int          wait_q = 0;
  logic        rd_q = 1'b0;
  logic [29:0] ra_q = 30'h0;
  initial begin
    gnt = 1'b0;
    rvalid = 1'b0;
    rdata = 32'h0;
  end
  always @(negedge clk) begin
    rvalid <= 1'b0;
    rdata  <= ~rdata;
    if (!reset_n) begin
      gnt <= 1'b0;
    end else if (gnt) begin
      gnt <= 1'b0;
      // read answer one cycle after its grant
      if (rd_q) begin
        rvalid <= 1'b1;
        rdata  <= mem.exists(ra_q) ? mem[ra_q] : ~rdata;
      end
    end else if (req) begin
      if (wait_q > 0) begin
        wait_q <= wait_q - 1;
      end else begin
        gnt    <= 1'b1;
        rd_q   <= !we;
        ra_q   <= addr[31:2]; // low address bits ignored
        wait_q <= slow ? ($random(seed) & 15) : ($random(seed) & 3);
        if (we) mem[addr[31:2]] = wdata;
      end
    end
  end
endmodule // fpec_mem_model

// >>> verif/fpec_top_chk.sv
// Purpose: port-level checker for the page corrector
// Assumes: bench holds the command inputs stable during a run
// Notes:   rmw pairing skipped for memory-sourced runs, fetches read too
`timescale 1ns/100ps
module fpec_top_chk (
  // clock and reset
  input wire        CLK,
  input wire        RESET_N,
  // command and media
  input wire        START,
  input wire        SRC_MEM,
  input wire        MEDIA_READY,
  // memory master
  input wire        MEM_REQ,
  input wire        MEM_WE,
  input wire [31:0] MEM_ADDR,
  input wire [31:0] MEM_WDATA,
  input wire        MEM_GNT,
  // status
  input wire        BUSY,
  input wire        DONE,
  input wire        STAT_VALID,
  input wire [4:0]  STAT_COUNT,
  input wire        STAT_UNCORR
);
  reg        pend_q;
  reg [31:0] ra_q;
  always @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      pend_q <= 1'b0;
      ra_q   <= 32'h0;
    end else if (MEM_REQ && MEM_GNT) begin
      pend_q <= !MEM_WE && !SRC_MEM;
      ra_q   <= MEM_ADDR;
    end
  end
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RESET_N);
  sequence s_wait; MEM_REQ && !MEM_GNT; endsequence
  sequence s_grant; MEM_REQ && MEM_GNT; endsequence
  sequence s_end; BUSY ##1 !BUSY; endsequence
  property p_done_pulse; DONE |=> !DONE; endproperty
  property p_done_end; DONE |-> s_end; endproperty
  property p_req_hold; s_wait |=> MEM_REQ && $stable(MEM_WE) && $stable(MEM_ADDR) && $stable(MEM_WDATA); endproperty
  property p_req_gap; s_grant |=> !MEM_REQ; endproperty
  property p_rmw; pend_q && MEM_REQ |-> MEM_WE && MEM_ADDR == ra_q; endproperty
  property p_idle; !BUSY |-> !MEDIA_READY && !MEM_REQ; endproperty
  property p_stat; STAT_VALID |-> BUSY && (STAT_UNCORR ? STAT_COUNT == 5'h0 : STAT_COUNT <= 5'h1); endproperty
  property p_start; $rose(START) && !BUSY |-> ##2 BUSY; endproperty
  a_done_pulse: assert property (p_done_pulse)
    else $error("done held longer than one cycle");
  a_done_end: assert property (p_done_end)
    else $error("done outside the end of a run");
  a_req_hold: assert property (p_req_hold)
    else $error("memory request changed before grant");
  a_req_gap: assert property (p_req_gap)
    else $error("memory request right after grant");
  a_rmw: assert property (p_rmw)
    else $error("correction read not followed by write back");
  a_idle: assert property (p_idle)
    else $error("traffic while idle");
  a_stat: assert property (p_stat)
    else $error("bad unit status");
  a_start: assert property (p_start)
    else $error("start not taken");
endmodule // fpec_top_chk
bind fpec_top fpec_top_chk chk_u (.CLK(CLK), .RESET_N(RESET_N), .START(START), .SRC_MEM(SRC_MEM),
  .MEDIA_READY(MEDIA_READY), .MEM_REQ(MEM_REQ), .MEM_WE(MEM_WE), .MEM_ADDR(MEM_ADDR),
  .MEM_WDATA(MEM_WDATA), .MEM_GNT(MEM_GNT), .BUSY(BUSY), .DONE(DONE), .STAT_VALID(STAT_VALID),
  .STAT_COUNT(STAT_COUNT), .STAT_UNCORR(STAT_UNCORR));

// >>> verif/fpec_top_tb.sv
// Purpose: self-checking bench for the page corrector
// Assumes: expected page image and status built from the layout rules
// Notes:   on decode runs one unit in three gets one flipped bit, one in three two
`timescale 1ns/100ps
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin err_count++; $display("Error %0t: got %h exp %h", $time, g, e); end end
module fpec_top_tb;
  logic        CLK, RESET_N, START, SRC_MEM, FIRST_ONLY, META_OWN, MEDIA_VALID;
  logic [1:0]  MODE;
  logic [4:0]  STRENGTH, STAT_COUNT;
  logic [7:0]  META_BYTES, BLOCK_COUNT, STAT_INDEX;
  logic [10:0] BLOCK_WORDS;
  logic [31:0] SRC_ADDR, DST_ADDR, MEDIA_DATA, MEM_ADDR, MEM_WDATA, MEM_RDATA;
  logic        MEDIA_READY, MEM_REQ, MEM_WE, MEM_GNT, MEM_RVALID, BUSY, DONE, STAT_VALID, STAT_UNCORR;
  int          seed = 11844;
  int          err_count = 0;
  int          comparisons = 0;
  int          cyc = 0;
  int          rd_cnt = 0;
  logic [31:0] strm[$], expm[$];
  logic [13:0] exps[$], gots[$];
  fpec_top #(.BW_W(11)) dut_u (.CLK(CLK), .RESET_N(RESET_N), .START(START), .MODE(MODE), .SRC_MEM(SRC_MEM),
    .FIRST_ONLY(FIRST_ONLY), .STRENGTH(STRENGTH), .META_BYTES(META_BYTES), .META_OWN(META_OWN),
    .BLOCK_WORDS(BLOCK_WORDS), .BLOCK_COUNT(BLOCK_COUNT), .SRC_ADDR(SRC_ADDR), .DST_ADDR(DST_ADDR),
    .MEDIA_VALID(MEDIA_VALID), .MEDIA_DATA(MEDIA_DATA), .MEDIA_READY(MEDIA_READY), .MEM_REQ(MEM_REQ),
    .MEM_WE(MEM_WE), .MEM_ADDR(MEM_ADDR), .MEM_WDATA(MEM_WDATA), .MEM_GNT(MEM_GNT), .MEM_RVALID(MEM_RVALID),
    .MEM_RDATA(MEM_RDATA), .BUSY(BUSY), .DONE(DONE), .STAT_VALID(STAT_VALID), .STAT_INDEX(STAT_INDEX),
    .STAT_COUNT(STAT_COUNT), .STAT_UNCORR(STAT_UNCORR));
  fpec_mem_model mem_u (.clk(CLK), .reset_n(RESET_N), .req(MEM_REQ), .we(MEM_WE), .addr(MEM_ADDR),
    .wdata(MEM_WDATA), .gnt(MEM_GNT), .rvalid(MEM_RVALID), .rdata(MEM_RDATA));
  always #5 CLK = ~CLK;
  always @(posedge CLK) begin
    if (STAT_VALID === 1'b1) gots.push_back({STAT_INDEX, STAT_COUNT, STAT_UNCORR});
    if (MEM_REQ === 1'b1 && MEM_GNT === 1'b1 && MEM_WE === 1'b0) rd_cnt++;
    cyc++;
    if (cyc == 90000) begin
      err_count++;
      test_done;
    end
  end
  function automatic logic [31:0] par(input logic [31:0] q[$]);
    logic [31:0] r;
    r = 32'h0;
    foreach (q[i]) for (int b = 0; b < 32; b++) if (q[i][b]) begin
      r[31] = ~r[31];
      r[15:0] = r[15:0] ^ {i[10:0], b[4:0]};
    end
    return r;
  endfunction
  task automatic run(input int md, st, mb, own, bw, bc, fo, sm);
    int p, mw, nu, n, j, b, e, fix;
    logic [31:0] c[$], u[$];
    strm = {};
    expm = {};
    exps = {};
    mem_u.mem.delete();
    fix = 0;
    p = (st > 20 ? 20 : st) / 2;
    mw = (mb + 3) / 4;
    nu = (own && mw) ? bc + 1 : bc;
    if (fo && md != 1) nu = nu - bc + 1;
    for (int k = 0; k < nu; k++) begin
      n = (own && mw) ? (k == 0 ? mw : bw) : (k == 0 ? mw + bw : bw);
      c = {};
      for (int i = 0; i < n; i++) c.push_back($random(seed));
      u = c;
      e = (md == 1) ? 0 : k % 3;
      j = {$random(seed)} % n;
      b = {$random(seed)} % 31;
      if (e > 0) u[j][b] = ~u[j][b];
      if (e > 1) u[j][b + 1] = ~u[j][b + 1];
      strm = {strm, u};
      if (md == 1) expm = {expm, c, par(c)};
      else if (p == 0 || e == 2) expm = {expm, u};
      else expm = {expm, c};
      if (md != 1 && p > 0) strm.push_back(par(c));
      for (int i = 1; i < p && md != 1; i++) strm.push_back(32'h0);
      for (int i = 1; i < p && md == 1; i++) expm.push_back(32'h0);
      if (md != 1) exps.push_back({k[7:0], (p > 0 && e == 1) ? 5'h1 : 5'h0, p > 0 && e == 2});
      if (md != 1 && p > 0 && e == 1) fix++;
    end
    if (sm) foreach (strm[i]) mem_u.mem[(32'h8000 >> 2) + i] = strm[i];
    @(negedge CLK);
    gots = {};
    rd_cnt = 0;
    MODE = md;
    STRENGTH = st;
    META_BYTES = mb;
    META_OWN = own;
    BLOCK_WORDS = bw;
    BLOCK_COUNT = bc;
    FIRST_ONLY = fo;
    SRC_MEM = sm;
    START = 1'b1;
    @(negedge CLK);
    START = 1'b0;
    if (!sm) foreach (strm[i]) begin
      MEDIA_VALID = 1'b1;
      MEDIA_DATA = strm[i];
      do @(posedge CLK); while (MEDIA_READY !== 1'b1);
      @(negedge CLK);
      if ($random(seed) & 1) begin
        MEDIA_VALID = 1'b0;
        MEDIA_DATA = ~MEDIA_DATA;
        @(negedge CLK);
      end
    end
    MEDIA_VALID = 1'b0;
    for (n = 0; n < 20000 && DONE !== 1'b1; n++) @(posedge CLK);
    `CHK(DONE, 1'b1)
    @(posedge CLK);
    foreach (expm[i]) `CHK(mem_u.mem[(32'h1000 >> 2) + i], expm[i])
    `CHK(mem_u.mem.exists((32'h1000 >> 2) + expm.size()), 0)
    `CHK(gots.size(), exps.size())
    foreach (exps[i]) `CHK(gots[i], exps[i])
    if (!sm) `CHK(rd_cnt, fix)
  endtask
  task test_done;
    $display("Comparisons %0d, mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  initial begin
    CLK = 1'b0;
    RESET_N = 1'b0;
    START = 1'b0;
    MODE = 2'h0;
    SRC_MEM = 1'b0;
    FIRST_ONLY = 1'b0;
    STRENGTH = 5'h0;
    META_BYTES = 8'h0;
    META_OWN = 1'b0;
    BLOCK_WORDS = 11'h0;
    BLOCK_COUNT = 8'h0;
    SRC_ADDR = 32'h8000; // word aligned
    DST_ADDR = 32'h1000; // word aligned
    MEDIA_VALID = 1'b0;
    MEDIA_DATA = 32'h0;
    repeat (16) @(negedge CLK);
    RESET_N = 1'b1;
    run(0, 4, 5, 1, 4, 3, 0, 0);
    run(0, 20, 7, 0, 3, 3, 1, 0);
    run(2, 6, 6, 1, 4, 3, 1, 0);
    run(0, 0, 4, 1, 4, 3, 0, 0);
    run(0, 2, 255, 1, 2, 1, 0, 0);
    run(1, 5, 3, 1, 4, 2, 0, 0);
    run(0, 6, 0, 0, 4, 3, 0, 1);
    run(1, 25, 0, 0, 2, 2, 0, 1);
    mem_u.slow = 1;
    run(0, 8, 0, 0, 24, 3, 0, 0);
    mem_u.slow = 0;
    for (int s = 2; s <= 20; s += 2) run(0, s, 0, 0, 2, 3, 0, 0);
    test_done;
  end
endmodule // fpec_top_tb
